// File: fpc_core.sv
// single precision classify, compare, normalize and encode datapath
`timescale 1ns/100ps

// Contract
// - value is sign, exponent, significand; 1 negative
// - 32-bit word, exponent bias 127
// - integer bit implied, not stored
// - normalize left, exponent down per shift
// - biased 1..254 is normal finite
// - exponent zero, fraction nonzero is denormal
// - below -126 shift right to -126
// - all bits shifted out gives zero
// - normalize whenever exponent range permits
// - denormal result raises underflow
// - denormal source raises denormal-operand
// - plus and minus zero compare equal
// - zero sign from operation and rounding
// - infinity is exponent 255, fraction zero
// - infinities ordered affinely around finites
// - infinities exact; invalid only when misused
// - exponent too large overflows to infinity
// - nan is max exponent, nonzero fraction
// - quiet bit set qnan, clear snan
// - qnan passes quietly; snan raises invalid
// - never produce an snan result
// - quieting sets top fraction bit only
module fpc_core #(
  parameter int WORD_W = 32,   // single precision word
  parameter int SIG_W  = 24,   // raw significand width incl. integer bit
  parameter int TEXP_W = 10    // raw signed true exponent width
) (
  // clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  // operation request
  input  wire logic                          valid_in,
  input  wire logic [1:0]                    op_in,
  input  wire logic [1:0]                    rmode_in,
  input  wire logic                          inv_mask_in,
  // operands
  input  wire logic [WORD_W-1:0]             opa_in,
  input  wire logic [WORD_W-1:0]             opb_in,
  // raw result to be normalized and encoded
  input  wire logic                          raw_sign_in,
  input  wire logic signed [TEXP_W-1:0]      raw_exp_in,
  input  wire logic [SIG_W-1:0]              raw_sig_in,
  input  wire logic                          raw_zero_sub_in,
  // operand class, registered one cycle after presentation
  output logic [fpc_pkg::FPC_CLS_W-1:0]      cls_a_out,
  output logic                               sign_a_out,
  output logic [fpc_pkg::FPC_CLS_W-1:0]      cls_b_out,
  output logic                               sign_b_out,
  // registered result
  output logic                               res_valid_out,
  output logic [WORD_W-1:0]                  res_out,
  output logic                               lt_out,
  output logic                               eq_out,
  output logic                               gt_out,
  output logic                               unord_out,
  // registered exception indications, one-cycle pulses
  output logic                               flag_uflow_out,
  output logic                               flag_oflow_out,
  output logic                               flag_denorm_out,
  output logic                               flag_inv_out,
  output logic                               trap_inv_out
);

  // ----------------------------------------------------------------------------
  // operand classification
  // ----------------------------------------------------------------------------
  logic [fpc_pkg::FPC_CLS_W-1:0] cls_a_w;   // class of a
  logic [fpc_pkg::FPC_CLS_W-1:0] cls_b_w;   // class of b
  logic                          sgn_a_w;   // sign of a
  logic                          sgn_b_w;   // sign of b

  fpc_classify #(.WORD_W(WORD_W)) u_cls_a (
    .opnd_in  (opa_in),
    .cls_out  (cls_a_w),
    .sign_out (sgn_a_w)
  );

  fpc_classify #(.WORD_W(WORD_W)) u_cls_b (
    .opnd_in  (opb_in),
    .cls_out  (cls_b_w),
    .sign_out (sgn_b_w)
  );

  // class outputs registered each edge from the presented operands
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cls_a_out  <= '0;
      sign_a_out <= fpc_pkg::FPC_POS;
      cls_b_out  <= '0;
      sign_b_out <= fpc_pkg::FPC_POS;
    end else begin
      cls_a_out  <= cls_a_w;
      sign_a_out <= sgn_a_w;
      cls_b_out  <= cls_b_w;
      sign_b_out <= sgn_b_w;
    end
  end

  logic nan_a_w;    // a is any nan
  logic nan_b_w;    // b is any nan
  logic snan_w;     // an snan operand takes part
  logic den_src_w;  // a denormal operand takes part
  logic inf_a_w;    // a is infinite
  logic inf_b_w;    // b is infinite

  assign nan_a_w = |(cls_a_w & (fpc_pkg::FPC_CLS_QNAN | fpc_pkg::FPC_CLS_SNAN));
  assign nan_b_w = |(cls_b_w & (fpc_pkg::FPC_CLS_QNAN | fpc_pkg::FPC_CLS_SNAN));
  assign inf_a_w = |(cls_a_w & fpc_pkg::FPC_CLS_INF);
  assign inf_b_w = |(cls_b_w & fpc_pkg::FPC_CLS_INF);

  // ----------------------------------------------------------------------------
  // comparison (affine, signed zeros equal)
  // ----------------------------------------------------------------------------
  logic [WORD_W-2:0] mag_a_w;   // magnitude of a
  logic [WORD_W-2:0] mag_b_w;   // magnitude of b
  logic              both_z_w;  // both are zeros of any sign
  logic              c_lt_w;    // a below b
  logic              c_eq_w;    // a equal to b

  assign mag_a_w  = opa_in[WORD_W-2:0];
  assign mag_b_w  = opb_in[WORD_W-2:0];
  assign both_z_w = (mag_a_w == '0) && (mag_b_w == '0);

  // magnitude order works for infinities too, so they sit beyond every finite
  always_comb begin
    c_eq_w = both_z_w || (opa_in == opb_in);
    if (c_eq_w) begin
      c_lt_w = 1'b0;
    end else if (sgn_a_w != sgn_b_w) begin
      c_lt_w = (sgn_a_w == fpc_pkg::FPC_NEG);
    end else if (sgn_a_w == fpc_pkg::FPC_NEG) begin
      c_lt_w = (mag_a_w > mag_b_w);
    end else begin
      c_lt_w = (mag_a_w < mag_b_w);
    end
  end

  // ----------------------------------------------------------------------------
  // normalize raw result
  // ----------------------------------------------------------------------------
  localparam int LZ_W = $clog2(SIG_W + 1);

  logic [LZ_W-1:0]          lz_w;      // leading zeros of raw significand
  logic                     rz_w;      // raw significand all zero
  logic signed [TEXP_W+1:0] nexp_w;    // exponent after left normalize
  logic [SIG_W-1:0]         nsig_w;    // left normalized significand
  logic signed [TEXP_W+1:0] sh_r_w;    // right shift for gradual underflow
  logic [SIG_W-1:0]         dsig_w;    // denormalized significand
  logic [WORD_W-1:0]        pack_w;    // encoded result
  logic                     pk_uf_w;   // denormal result created
  logic                     pk_of_w;   // overflow to infinity
  logic                     zsign_w;   // sign of an exact zero result
  logic [fpc_pkg::FPC_EXP_W-1:0] bexp_w; // biased exponent

  // leading zero count, integer bit at the top of the raw significand
  always_comb begin
    lz_w = LZ_W'(SIG_W);
    for (int i = 0; i < SIG_W; i++) begin
      if (raw_sig_in[i]) begin
        lz_w = LZ_W'(SIG_W - 1 - i);
      end
    end
  end

  assign rz_w   = (raw_sig_in == '0);
  assign nsig_w = raw_sig_in << lz_w;
  assign nexp_w = (TEXP_W+2)'(raw_exp_in) - (TEXP_W+2)'(signed'({1'b0, lz_w}));
  assign sh_r_w = (TEXP_W+2)'(fpc_pkg::FPC_TEXP_MIN) - nexp_w;
  assign dsig_w = (sh_r_w >= (TEXP_W+2)'(SIG_W)) ? '0 : (nsig_w >> sh_r_w);
  assign bexp_w = fpc_pkg::FPC_EXP_W'(nexp_w + (TEXP_W+2)'(fpc_pkg::FPC_BIAS));

  // exact zero sign: equal opposite sum is minus only when rounding down
  always_comb begin
    if (raw_zero_sub_in) begin
      zsign_w = (fpc_pkg::fpc_rm_t'(rmode_in) == fpc_pkg::FPC_RM_DOWN) ? fpc_pkg::FPC_NEG
                                                                       : fpc_pkg::FPC_POS;
    end else begin
      zsign_w = raw_sign_in;
    end
  end

  // encode: zero, denormal, normal or overflow
  always_comb begin
    pk_uf_w = 1'b0;
    pk_of_w = 1'b0;
    if (rz_w) begin
      pack_w = {zsign_w, {(WORD_W-1){1'b0}}};
    end else if (nexp_w > (TEXP_W+2)'(fpc_pkg::FPC_TEXP_MAX)) begin
      pk_of_w = 1'b1;
      pack_w  = {raw_sign_in, fpc_pkg::FPC_EXP_MAX, {fpc_pkg::FPC_FRAC_W{1'b0}}};
    end else if (nexp_w < (TEXP_W+2)'(fpc_pkg::FPC_TEXP_MIN)) begin
      pk_uf_w = (dsig_w != '0);
      // integer bit of a denormal is zero; exponent field zero
      pack_w  = {raw_sign_in, fpc_pkg::FPC_EXP_ZERO,
                 dsig_w[fpc_pkg::FPC_FRAC_W-1:0]};
    end else begin
      // integer bit dropped, implied in the encoding
      pack_w = {raw_sign_in, bexp_w, nsig_w[SIG_W-2:SIG_W-1-fpc_pkg::FPC_FRAC_W]};
    end
  end

  // ----------------------------------------------------------------------------
  // nan handling for compare and pass
  // ----------------------------------------------------------------------------
  logic [WORD_W-1:0] quiet_a_w;  // a with quiet bit forced
  logic              inv_w;      // invalid operation this request
  logic [1:0]        op_q_w;     // current operation code

  assign op_q_w    = op_in;
  assign quiet_a_w = opa_in | (WORD_W'(1) << fpc_pkg::FPC_FRAC_HI);
  assign snan_w    = |((cls_a_w | ((op_q_w == fpc_pkg::FPC_OP_CMP) ? cls_b_w : '0))
                       & fpc_pkg::FPC_CLS_SNAN);
  assign den_src_w = |((cls_a_w | ((op_q_w == fpc_pkg::FPC_OP_CMP) ? cls_b_w : '0))
                       & fpc_pkg::FPC_CLS_DEN);

  // qnan propagates quietly; snan flags invalid; infinities alone never do
  assign inv_w = snan_w;

  // ----------------------------------------------------------------------------
  // result register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      res_valid_out <= 1'b0;
      res_out       <= '0;
      lt_out        <= 1'b0;
      eq_out        <= 1'b0;
      gt_out        <= 1'b0;
      unord_out     <= 1'b0;
    end else begin
      res_valid_out <= valid_in && (op_q_w != fpc_pkg::FPC_OP_NONE);
      lt_out        <= 1'b0;
      eq_out        <= 1'b0;
      gt_out        <= 1'b0;
      unord_out     <= 1'b0;
      if (valid_in) begin
        case (fpc_pkg::fpc_op_t'(op_q_w))
          fpc_pkg::FPC_OP_PACK: begin
            res_out <= pack_w;
          end
          fpc_pkg::FPC_OP_CMP: begin
            res_out <= '0;
            if (nan_a_w || nan_b_w) begin
              unord_out <= 1'b1;
            end else begin
              lt_out <= c_lt_w;
              eq_out <= c_eq_w;
              gt_out <= !c_lt_w && !c_eq_w;
            end
          end
          fpc_pkg::FPC_OP_PASS: begin
            // snan leaves only as its quiet form; infinities pass exactly
            res_out <= nan_a_w ? quiet_a_w : opa_in;
          end
          default: begin
            res_out <= res_out;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // exception indications
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flag_uflow_out  <= 1'b0;
      flag_oflow_out  <= 1'b0;
      flag_denorm_out <= 1'b0;
      flag_inv_out    <= 1'b0;
      trap_inv_out    <= 1'b0;
    end else begin
      flag_uflow_out  <= valid_in && (op_q_w == fpc_pkg::FPC_OP_PACK) && pk_uf_w;
      flag_oflow_out  <= valid_in && (op_q_w == fpc_pkg::FPC_OP_PACK) && pk_of_w;
      flag_denorm_out <= valid_in && (op_q_w != fpc_pkg::FPC_OP_PACK)
                         && (op_q_w != fpc_pkg::FPC_OP_NONE) && den_src_w;
      flag_inv_out    <= valid_in && (op_q_w != fpc_pkg::FPC_OP_PACK)
                         && (op_q_w != fpc_pkg::FPC_OP_NONE) && inv_w;
      trap_inv_out    <= valid_in && (op_q_w != fpc_pkg::FPC_OP_PACK)
                         && (op_q_w != fpc_pkg::FPC_OP_NONE) && inv_w
                         && !inv_mask_in;
    end
  end

  // unused infinity terms kept for readability of the compare path
  logic unused_w;
  assign unused_w = inf_a_w ^ inf_b_w ^ fpc_pkg::FPC_EXP_NMAX[0] ^ fpc_pkg::FPC_EXP_NMIN[0];

endmodule : fpc_core

// File: fpc_pkg.sv
// package of formats, class codes and operations for the single precision classifier
package fpc_pkg;

  // ----------------------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------------------
  localparam int          FPC_WORD_W  = 32;        // single precision word width
  localparam int          FPC_EXP_W   = 8;         // biased exponent width
  localparam int          FPC_FRAC_W  = 23;        // stored fraction width
  localparam int          FPC_SIG_W   = 24;        // significand with integer bit
  localparam int          FPC_SIGN_B  = 31;        // sign bit position
  localparam int          FPC_EXP_HI  = 30;        // exponent top bit
  localparam int          FPC_EXP_LO  = 23;        // exponent low bit
  localparam int          FPC_FRAC_HI = 22;        // fraction top bit (quiet bit)
  localparam int          FPC_TEXP_W  = 10;        // signed true exponent width

  // ----------------------------------------------------------------------------
  // exponent constants
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  FPC_EXP_ZERO = 8'h00;     // zero or denormal
  localparam logic [7:0]  FPC_EXP_MAX  = 8'hFF;     // infinity or nan (255)
  localparam logic [7:0]  FPC_EXP_NMAX = 8'hFE;     // largest normal (254)
  localparam logic [7:0]  FPC_EXP_NMIN = 8'h01;     // smallest normal (1)
  localparam logic signed [9:0] FPC_BIAS     = 10'sd127;  // exponent bias
  localparam logic signed [9:0] FPC_TEXP_MIN = -10'sd126; // least normal true exponent
  localparam logic signed [9:0] FPC_TEXP_MAX = 10'sd127;  // largest normal true exponent
  localparam logic        FPC_POS      = 1'b0;      // positive sign
  localparam logic        FPC_NEG      = 1'b1;      // negative sign

  // ----------------------------------------------------------------------------
  // one-hot class codes
  // ----------------------------------------------------------------------------
  localparam int          FPC_CLS_W    = 6;
  localparam logic [5:0]  FPC_CLS_ZERO = 6'h01;     // signed zero
  localparam logic [5:0]  FPC_CLS_DEN  = 6'h02;     // denormal
  localparam logic [5:0]  FPC_CLS_NORM = 6'h04;     // normal finite
  localparam logic [5:0]  FPC_CLS_INF  = 6'h08;     // signed infinity
  localparam logic [5:0]  FPC_CLS_QNAN = 6'h10;     // quiet nan
  localparam logic [5:0]  FPC_CLS_SNAN = 6'h20;     // signaling nan

  // ----------------------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    FPC_OP_PACK = 2'b00,   // normalize and encode a raw result
    FPC_OP_CMP  = 2'b01,   // compare a against b
    FPC_OP_PASS = 2'b11,   // unary pass of a (nan quieting)
    FPC_OP_NONE = 2'b10    // idle
  } fpc_op_t;

  // zero result sign under each rounding mode
  typedef enum logic [1:0] {
    FPC_RM_NEAR = 2'b00,
    FPC_RM_DOWN = 2'b01,
    FPC_RM_UP   = 2'b10,
    FPC_RM_ZERO = 2'b11
  } fpc_rm_t;

endpackage : fpc_pkg

// File: fpc_classify.sv
// combinational classifier for one single precision operand
`timescale 1ns/100ps

module fpc_classify #(
  parameter int WORD_W = 32
) (
  // operand
  input  wire logic [WORD_W-1:0]          opnd_in,
  // class and sign
  output logic [fpc_pkg::FPC_CLS_W-1:0]   cls_out,
  output logic                            sign_out
);

  logic [fpc_pkg::FPC_EXP_W-1:0]  exp_w;   // biased exponent field
  logic [fpc_pkg::FPC_FRAC_W-1:0] frac_w;  // fraction field
  logic                           fz_w;    // fraction is all zero

  // ----------------------------------------------------------------------------
  // field split
  // ----------------------------------------------------------------------------
  assign exp_w  = opnd_in[fpc_pkg::FPC_EXP_HI:fpc_pkg::FPC_EXP_LO];
  assign frac_w = opnd_in[fpc_pkg::FPC_FRAC_HI:0];
  assign fz_w   = (frac_w == '0);

  // sign is reported as seen; nan class ignores it
  assign sign_out = opnd_in[fpc_pkg::FPC_SIGN_B];

  // class decode by exponent and fraction
  always_comb begin
    if (exp_w == fpc_pkg::FPC_EXP_ZERO) begin
      cls_out = fz_w ? fpc_pkg::FPC_CLS_ZERO : fpc_pkg::FPC_CLS_DEN;
    end else if (exp_w == fpc_pkg::FPC_EXP_MAX) begin
      if (fz_w) begin
        cls_out = fpc_pkg::FPC_CLS_INF;
      end else if (frac_w[fpc_pkg::FPC_FRAC_HI]) begin
        cls_out = fpc_pkg::FPC_CLS_QNAN;
      end else begin
        cls_out = fpc_pkg::FPC_CLS_SNAN;
      end
    end else begin
      cls_out = fpc_pkg::FPC_CLS_NORM;
    end
  end

endmodule : fpc_classify

// File: fpc_core_asserts.sv
// assertion checker for the single precision classify datapath
`timescale 1ns/100ps

module fpc_core_chk (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  // request
  input wire logic        valid_in,
  input wire logic [1:0]  op_in,
  input wire logic        inv_mask_in,
  input wire logic [31:0] opa_in,
  input wire logic [31:0] opb_in,
  // answers
  input wire logic [5:0]  cls_a_out,
  input wire logic        sign_a_out,
  input wire logic        res_valid_out,
  input wire logic [31:0] res_out,
  input wire logic        eq_out,
  input wire logic        flag_denorm_out,
  input wire logic        flag_inv_out,
  input wire logic        trap_inv_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // ---------------------------------------------------------------
  // request decode helpers
  // ---------------------------------------------------------------
  wire logic [7:0] exp_a  = opa_in[30:23];            // operand a exponent
  wire logic       fz_a   = opa_in[22:0] == 23'h0;    // operand a fraction zero
  wire logic       vcmp   = valid_in && op_in == 2'h1;
  wire logic       vpass  = valid_in && op_in == 2'h3;
  wire logic       snan_a = exp_a == 8'hFF && !fz_a && !opa_in[22];

  // ---------------------------------------------------------------
  // class codes, one cycle after presentation
  // ---------------------------------------------------------------
  a_cls_den: assert property (
    $past(rst_n_in) && $past(exp_a) == 8'h00 && !$past(fz_a) |-> cls_a_out == 6'h02)
    else $error("denormal class wrong");
  a_cls_norm: assert property (
    $past(rst_n_in) && $past(exp_a) inside {[8'h01:8'hFE]} |-> cls_a_out == 6'h04)
    else $error("normal class wrong");
  a_cls_inf: assert property (
    $past(rst_n_in) && $past(exp_a) == 8'hFF && $past(fz_a)
    |-> cls_a_out == 6'h08 && sign_a_out == $past(opa_in[31]))
    else $error("infinity class wrong");
  a_cls_nan: assert property (
    $past(rst_n_in) && $past(exp_a) == 8'hFF && !$past(fz_a)
    |-> cls_a_out == ($past(opa_in[22]) ? 6'h10 : 6'h20))
    else $error("nan class wrong");

  // ---------------------------------------------------------------
  // results and indications
  // ---------------------------------------------------------------
  a_zero_eq: assert property (
    vcmp && opa_in[30:0] == 31'h0 && opb_in[30:0] == 31'h0 |=> res_valid_out && eq_out)
    else $error("signed zeros not equal");
  a_pass_quiet: assert property (
    vpass && snan_a |=> res_out == ($past(opa_in) | 32'h0040_0000) && flag_inv_out
    && trap_inv_out == !$past(inv_mask_in))
    else $error("signaling nan not quieted");
  a_no_snan: assert property (
    res_valid_out |-> !(res_out[30:23] == 8'hFF && res_out[22:0] != 23'h0 && !res_out[22]))
    else $error("signaling nan produced");
  a_denorm_src: assert property (
    vcmp && opb_in[30:23] == 8'h00 && opb_in[22:0] != 23'h0 |=> flag_denorm_out)
    else $error("denormal operand not flagged");

  // main scenarios reached
  c_quiet: cover property (vpass && snan_a);
  c_eq: cover property (eq_out);
  c_den: cover property (flag_denorm_out);
endmodule : fpc_core_chk

bind fpc_core fpc_core_chk u_chk (.clk_in, .rst_n_in, .valid_in, .op_in, .inv_mask_in,
  .opa_in, .opb_in, .cls_a_out, .sign_a_out, .res_valid_out, .res_out, .eq_out,
  .flag_denorm_out, .flag_inv_out, .trap_inv_out);

// File: fpc_pipe_sink.sv
// result sink model of the execution pipeline behind the datapath
`timescale 1ns/100ps

module fpc_pipe_sink (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // results from the datapath
  input  wire logic        res_valid_in,
  input  wire logic [31:0] res_in,
  // retire count and last word
  output logic [15:0]      taken_out,
  output logic [31:0]      last_out
);
  // retire one word per result pulse, it stands a single cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      taken_out <= 16'h0000;
      last_out  <= 32'h0000_0000;
    end else if (res_valid_in) begin
      taken_out <= taken_out + 16'h0001;
      last_out  <= res_in;
    end
  end
endmodule : fpc_pipe_sink

// File: fpc_core_tb_top.sv
// self-checking testbench of the single precision classify datapath
`timescale 1ns/100ps

module fpc_core_tb_top;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic              clk_in, rst_n_in, valid_in, inv_mask_in;
  logic [1:0]        op_in, rmode_in;
  logic [31:0]       opa_in, opb_in, res_out, last;
  logic              raw_sign_in, raw_zero_sub_in;
  logic signed [9:0] raw_exp_in;
  logic [23:0]       raw_sig_in;
  logic [5:0]        cls_a_out, cls_b_out;
  logic              sign_a_out, sign_b_out, res_valid_out, lt_out, eq_out, gt_out;
  logic              unord_out, flag_uflow_out, flag_oflow_out, flag_denorm_out;
  logic              flag_inv_out, trap_inv_out;
  logic [15:0]       taken, issued;
  int                errors, checked, cycles;
  wire logic [9:0]   flags = {res_valid_out, lt_out, eq_out, gt_out, unord_out,
    flag_uflow_out, flag_oflow_out, flag_denorm_out, flag_inv_out, trap_inv_out};

  fpc_core dut (.clk_in, .rst_n_in, .valid_in, .op_in, .rmode_in, .inv_mask_in, .opa_in,
    .opb_in, .raw_sign_in, .raw_exp_in, .raw_sig_in, .raw_zero_sub_in, .cls_a_out,
    .sign_a_out, .cls_b_out, .sign_b_out, .res_valid_out, .res_out, .lt_out, .eq_out,
    .gt_out, .unord_out, .flag_uflow_out, .flag_oflow_out, .flag_denorm_out,
    .flag_inv_out, .trap_inv_out);
  fpc_pipe_sink u_sink (.clk_in, .rst_n_in, .res_valid_in(res_valid_out), .res_in(res_out),
    .taken_out(taken), .last_out(last));

  // ---------------------------------------------------------------
  // clock, timeout and closing report
  // ---------------------------------------------------------------
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------
  // compares, expected class and request driver
  // ---------------------------------------------------------------
  task automatic chk_word(input logic [31:0] exp_v, input logic [31:0] got_v);
    checked++;
    if (got_v !== exp_v) begin
      errors++;
      $display("[FAIL] %0t word %h expected %h", $time, got_v, exp_v);
    end
  endtask : chk_word
  task automatic chk_flg(input logic [9:0] exp_v, input logic [9:0] got_v);
    checked++;
    if (got_v !== exp_v) begin
      errors++;
      $display("[FAIL] %0t flags %h expected %h", $time, got_v, exp_v);
    end
  endtask : chk_flg
  function automatic logic [5:0] cls_of(input logic [31:0] w);
    if (w[30:23] == 8'h00) return (w[22:0] == 23'h0) ? 6'h01 : 6'h02;
    if (w[30:23] != 8'hFF) return 6'h04;
    if (w[22:0] == 23'h0) return 6'h08;
    return w[22] ? 6'h10 : 6'h20;
  endfunction : cls_of
  // entered at a falling edge; returns one cycle later with the answer settled
  task automatic req(input logic [1:0] op_v, input logic [31:0] a_v, b_v);
    valid_in = 1'b1;
    op_in    = op_v;
    opa_in   = a_v;
    opb_in   = b_v;
    if (op_v != 2'h2) issued++;
    @(negedge clk_in);
  endtask : req
  task automatic cmp(input logic [31:0] a_v, b_v, input logic m_v, input logic [9:0] f_v);
    inv_mask_in = m_v;
    req(2'h1, a_v, b_v);
    chk_flg(f_v, flags);
  endtask : cmp
  task automatic pass(input logic [31:0] a_v, input logic m_v, input logic [31:0] w_v,
                      input logic [9:0] f_v);
    inv_mask_in = m_v;
    req(2'h3, a_v, 32'h3F80_0000);
    chk_word(w_v, res_out);
    chk_flg(f_v, flags);
  endtask : pass
  task automatic pack(input logic s_v, input int e_v, input logic [23:0] m_v,
                      input logic [2:0] zr_v, input logic [31:0] w_v, input logic [9:0] f_v);
    raw_sign_in     = s_v;
    raw_exp_in      = 10'(e_v);
    raw_sig_in      = m_v;
    raw_zero_sub_in = zr_v[2];
    rmode_in        = zr_v[1:0];
    req(2'h0, 32'h0000_0000, 32'h0000_0000);
    chk_word(w_v, res_out);
    chk_flg(f_v, flags);
  endtask : pack

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_classify();
    logic [31:0] v [8];
    v = '{32'h8000_0000, 32'h0000_0001, 32'h0080_0000, 32'h7F7F_FFFF,
          32'hFF80_0000, 32'h7FC0_0000, 32'h7F80_0001, 32'hFF80_0001};
    for (int i = 0; i < 8; i++) begin
      req(2'h2, v[i], v[7-i]);
      chk_word({25'h0, v[i][31], cls_of(v[i])}, {25'h0, sign_a_out, cls_a_out});
      chk_word({25'h0, v[7-i][31], cls_of(v[7-i])}, {25'h0, sign_b_out, cls_b_out});
      chk_flg(10'h000, flags);
    end
  endtask : t_classify
  task automatic t_compare();
    cmp(32'h8000_0000, 32'h0000_0000, 1'b1, 10'h280);
    cmp(32'hFF80_0000, 32'hFF7F_FFFF, 1'b1, 10'h300);
    cmp(32'h7F80_0000, 32'h7F7F_FFFF, 1'b1, 10'h240);
    cmp(32'h7F80_0000, 32'h7F80_0000, 1'b0, 10'h280);
    cmp(32'h7FC0_0000, 32'h3F80_0000, 1'b0, 10'h220);
    cmp(32'h7F80_0001, 32'h3F80_0000, 1'b0, 10'h223);
    cmp(32'h3F80_0000, 32'h0000_0001, 1'b1, 10'h244);
  endtask : t_compare
  task automatic t_pass();
    pass(32'h7F80_0001, 1'b1, 32'h7FC0_0001, 10'h202);
    pass(32'hFF80_0005, 1'b0, 32'hFFC0_0005, 10'h203);
    pass(32'h7FC0_0005, 1'b0, 32'h7FC0_0005, 10'h200);
    pass(32'hFF80_0000, 1'b0, 32'hFF80_0000, 10'h200);
    pass(32'h0000_0003, 1'b1, 32'h0000_0003, 10'h204);
  endtask : t_pass
  task automatic t_pack();
    pack(1'b0, -129, 24'hAE_0000, 3'h0, 32'h0015_C000, 10'h210);
    pack(1'b0, 7, 24'hB2_2000, 3'h0, 32'h4332_2000, 10'h200);
    pack(1'b0, 9, 24'h2C_8800, 3'h0, 32'h4332_2000, 10'h200);
    pack(1'b1, -125, 24'h40_0000, 3'h0, 32'h8080_0000, 10'h200);
    pack(1'b1, -160, 24'h80_0000, 3'h0, 32'h8000_0000, 10'h200);
    pack(1'b0, 128, 24'h80_0000, 3'h0, 32'h7F80_0000, 10'h208);
    pack(1'b0, 127, 24'hFF_FFFF, 3'h0, 32'h7F7F_FFFF, 10'h200);
    pack(1'b0, 0, 24'h00_0000, 3'h4, 32'h0000_0000, 10'h200);
    pack(1'b0, 0, 24'h00_0000, 3'h5, 32'h8000_0000, 10'h200);
    pack(1'b0, 0, 24'h00_0000, 3'h6, 32'h0000_0000, 10'h200);
  endtask : t_pack

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {clk_in, rst_n_in, valid_in, inv_mask_in, raw_sign_in, raw_zero_sub_in} = 6'h00;
    {op_in, rmode_in, opa_in, opb_in, raw_sig_in} = {4'h8, 88'h0};
    raw_exp_in = 10'sd0;
    {errors, checked, cycles, issued} = 0;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    chk_flg(10'h000, flags);
    chk_word(32'h0000_0000, res_out);
    rst_n_in = 1'b1;
    t_classify();
    t_compare();
    t_pass();
    t_pack();
    valid_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk_word({16'h0000, issued}, {16'h0000, taken});
    chk_word(32'h0000_0000, last);
    end_sim();
  end
endmodule : fpc_core_tb_top
